// ===== design/vp_pkg.sv
// ****************************************************************
// Constants shared by the predication and half-precision block
// ****************************************************************
package vp_pkg;

	// ************************************************************
	// Register bus
	// ************************************************************
	localparam int          ADDR_W              = 8;
	localparam int          DATA_W              = 32;
	localparam logic [7:0]  FP_CONTROL_OFFSET   = 8'h00;
	localparam logic [7:0]  FP_STATUS_OFFSET    = 8'h04;
	localparam logic [7:0]  FAULT_MASK_OFFSET   = 8'h08;
	localparam logic [7:0]  COMMAND_OFFSET      = 8'h0C;
	localparam logic [7:0]  ELEMENT_INFO_OFFSET = 8'h10;
	localparam logic [7:0]  IRQ_STATUS_OFFSET   = 8'h14;
	localparam logic [7:0]  IRQ_MASK_OFFSET     = 8'h18;

	// ************************************************************
	// Floating-point control fields
	// ************************************************************
	localparam int          FLUSH_ZERO_SINGLE_DOUBLE_BIT = 0;
	localparam int          FLUSH_ZERO_HALF_BIT          = 1;
	localparam int          ALT_HALF_FORMAT_BIT          = 2;
	localparam int          TRAP_ENABLE_LSB              = 8;
	localparam int          INPUT_DENORMAL_TRAP_BIT      = 15;
	localparam int          EXC_W                        = 5;
	localparam logic [31:0] CONTROL_WRITE_MASK           = 32'h0000_9F07;
	localparam logic [31:0] CONTROL_RESET                = 32'h0000_0000;

	// ************************************************************
	// Floating-point status fields
	// ************************************************************
	localparam int          EXC_FLAG_LSB        = 0;
	localparam int          INPUT_DENORMAL_BIT  = 7;
	localparam logic [31:0] STATUS_WRITE_MASK   = 32'h0000_009F;
	localparam logic [31:0] STATUS_RESET        = 32'h0000_0000;

	// ************************************************************
	// Command, element information and interrupt fields
	// ************************************************************
	localparam int          CMD_SET_ALL_BIT     = 0;
	localparam int          INFO_FIRST_LSB      = 0;
	localparam int          INFO_LAST_LSB       = 8;
	localparam int          INFO_ANY_BIT        = 16;
	localparam int          IRQ_W               = 4;
	localparam int          IRQ_FAULT_TAKEN     = 0;
	localparam int          IRQ_FAULT_SUPPRESS  = 1;
	localparam int          IRQ_FP_TRAP         = 2;
	localparam int          IRQ_INPUT_DENORMAL  = 3;
	localparam logic [3:0]  IRQ_RESET           = 4'h0;

	// ************************************************************
	// Instruction kinds, one-hot
	// ************************************************************
	typedef enum logic [3:0] {
		OP_PLAIN       = 4'h1,
		OP_LOAD        = 4'h2,
		OP_FIRST_FAULT = 4'h4,
		OP_NON_FAULT   = 4'h8
	} op_kind_type;

endpackage : vp_pkg

// ===== design/vector_predication_fp16_control.sv
// Overview of operation
// - Half-precision operations use the same exception traps and trap enables as wider ones.
// - The single/double flush-to-zero bit has no effect on half-precision operations.
// - The half flush bit flushes denormals in half operations except half/wider conversions.
// - A half value flushed by the half flush bit never sets the input-denormal flag.
// - Half operations always use the standard half format, treating the alternate bit as 0.
// - An element is active when its governing predicate element is true, else inactive.
// - An unpredicated instruction treats every element of its registers as active.
// - The first active element is the active element with the lowest number.
// - The last active element is the active element with the highest number.
// - A first-fault load takes only a first-active-element fault and records the rest.
// - A non-fault load suppresses every fault and records unloaded active elements.
// - A predicate element is true when its lowest-numbered bit is one.
// - Set-all makes every fault mask element true; a failed element clears itself and up.
// - Inactive destination elements are zeroed or kept per zeroing or merging mode.
`timescale 1ns/100ps
module vector_predication_fp16_control #(
	parameter int BYTES = 16
) (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic      [31:0]             reg_rdata,
	input  wire logic                    op_valid,
	input  vp_pkg::op_kind_type          op_kind,
	input  wire logic                    op_predicated,
	input  wire logic                    op_zeroing,
	input  wire logic [1:0]              op_elem_size,
	input  wire logic [BYTES-1:0]        op_pred,
	input  wire logic [BYTES-1:0]        op_fault,
	input  wire logic [8*BYTES-1:0]      op_old_data,
	input  wire logic [8*BYTES-1:0]      op_new_data,
	output logic                         result_valid,
	output logic      [8*BYTES-1:0]      result_data,
	output logic      [BYTES-1:0]        result_active,
	output logic                         fault_take,
	output logic      [$clog2(BYTES)-1:0] first_active_index,
	output logic      [$clog2(BYTES)-1:0] last_active_index,
	output logic                         any_active,
	input  wire logic                    fp_valid,
	input  wire logic                    fp_half,
	input  wire logic                    fp_convert,
	input  wire logic                    fp_input_denormal,
	input  wire logic [4:0]              fp_exceptions,
	output logic                         fp_done,
	output logic                         fp_flush,
	output logic                         fp_alt_half,
	output logic                         fp_trap,
	output logic                         irq
);

	localparam int IDX_W = $clog2(BYTES);

	// ************************************************************
	// Parameter check
	// ************************************************************
	// Lane count must hold a 64-bit element and fit one data word
	if (BYTES < 8 || BYTES > 32 || (BYTES & (BYTES - 1)) != 0) begin : g_bad_bytes
		$error("BYTES must be a power of two from 8 to 32");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [31:0]              rdata;
		logic [31:0]              fp_control;
		logic [31:0]              fp_status;
		logic [BYTES-1:0]         fault_mask;
		logic [vp_pkg::IRQ_W-1:0] irq_status;
		logic [vp_pkg::IRQ_W-1:0] irq_mask;
		logic                     irq;
		logic                     result_valid;
		logic [8*BYTES-1:0]       result_data;
		logic [BYTES-1:0]         result_active;
		logic                     fault_take;
		logic [IDX_W-1:0]         first_index;
		logic [IDX_W-1:0]         last_index;
		logic                     any_active;
		logic                     fp_done;
		logic                     fp_flush;
		logic                     fp_alt_half;
		logic                     fp_trap;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// ************************************************************
	// Per-lane predication
	// ************************************************************
	logic [IDX_W-1:0]   size_low;
	logic [BYTES-1:0]   lane_active;
	logic [BYTES-1:0]   elem_base;
	logic [BYTES-1:0]   base_active;
	logic [BYTES-1:0]   base_fault;
	logic [BYTES-1:0]   below_fault;
	logic [8*BYTES-1:0] merged_data;
	logic [IDX_W-1:0]   fault_lane;

	// Lanes below the element size boundary belong to the element at the base
	assign size_low = IDX_W'((5'h01 << op_elem_size) - 5'h01);

	genvar lane;
	generate
		for (lane = 0; lane < BYTES; lane++) begin : g_lane
			logic [IDX_W-1:0] base_idx;
			assign base_idx = IDX_W'(lane) & ~size_low;
			// Lowest bit of the predicate element decides, unpredicated is all active
			assign lane_active[lane] = !op_predicated || op_pred[base_idx];
			assign elem_base[lane] = (IDX_W'(lane) & size_low) == '0;
			assign base_active[lane] = lane_active[lane] && elem_base[lane];
			// Faults count only at the base lane of an active element
			assign base_fault[lane] = base_active[lane] && op_fault[lane];
			assign below_fault[lane] = IDX_W'(lane) < (fault_lane & ~size_low);
			// Inactive lanes are zeroed or keep the old value
			assign merged_data[8*lane +: 8] = lane_active[lane] ? op_new_data[8*lane +: 8] :
				(op_zeroing ? 8'h00 : op_old_data[8*lane +: 8]);
		end
	endgenerate

	// ************************************************************
	// First and last active element, lowest faulting element
	// ************************************************************
	logic [IDX_W-1:0] first_lane;
	logic [IDX_W-1:0] last_lane;
	logic             found_active;
	logic             found_fault;

	// Scan up for the last, down for the first and for the lowest fault
	always_comb begin
		first_lane = '0;
		last_lane = '0;
		fault_lane = '0;
		found_active = 1'b0;
		found_fault = 1'b0;
		for (int i = 0; i < BYTES; i++) begin
			if (base_active[i]) begin
				last_lane = IDX_W'(i);
				found_active = 1'b1;
			end
		end
		for (int i = BYTES - 1; i >= 0; i--) begin
			if (base_active[i]) begin
				first_lane = IDX_W'(i);
			end
			if (base_fault[i]) begin
				fault_lane = IDX_W'(i);
				found_fault = 1'b1;
			end
		end
	end

	// ************************************************************
	// Fault decision
	// ************************************************************
	logic first_faults;
	logic take_now;
	logic suppress_now;

	assign first_faults = found_fault && (fault_lane == first_lane);

	// Plain loads fault on any active element, the two speculative kinds record
	always_comb begin
		take_now = 1'b0;
		suppress_now = 1'b0;
		if (op_valid) begin
			case (op_kind)
				vp_pkg::OP_LOAD: begin
					take_now = found_fault;
				end
				vp_pkg::OP_FIRST_FAULT: begin
					take_now = first_faults;
					suppress_now = found_fault && !first_faults;
				end
				vp_pkg::OP_NON_FAULT: begin
					suppress_now = found_fault;
				end
				default: begin
					take_now = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Half-precision controls
	// ************************************************************
	logic       ctl_fz;
	logic       ctl_flush_zero_half;
	logic       ctl_ahp;
	logic       flush_now;
	logic       idc_now;
	logic       ide_trap_now;
	logic [4:0] trap_en;
	logic [4:0] trapped;
	logic [4:0] untrapped;

	assign ctl_fz = state_reg.fp_control[vp_pkg::FLUSH_ZERO_SINGLE_DOUBLE_BIT];
	assign ctl_flush_zero_half = state_reg.fp_control[vp_pkg::FLUSH_ZERO_HALF_BIT];
	assign ctl_ahp = state_reg.fp_control[vp_pkg::ALT_HALF_FORMAT_BIT];
	assign trap_en = state_reg.fp_control[vp_pkg::TRAP_ENABLE_LSB +: vp_pkg::EXC_W];

	// Half ignores the wide flush bit and flushes only outside conversions
	assign flush_now = fp_half ? (ctl_flush_zero_half && !fp_convert) : ctl_fz;
	// A half-precision flush never reports an input denormal
	assign idc_now = fp_valid && !fp_half && ctl_fz && fp_input_denormal;
	assign ide_trap_now = idc_now && state_reg.fp_control[vp_pkg::INPUT_DENORMAL_TRAP_BIT];
	// Same trap enables for every precision
	assign trapped = fp_valid ? (fp_exceptions & trap_en) : 5'h00;
	assign untrapped = fp_valid ? (fp_exceptions & ~trap_en) : 5'h00;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	logic [31:0] info_word;
	logic        wr_control;
	logic        wr_status;
	logic        wr_command;
	logic        wr_irq_status;
	logic        wr_irq_mask;
	logic [3:0]  irq_events;

	always_comb begin
		info_word = 32'h0000_0000;
		info_word[vp_pkg::INFO_FIRST_LSB +: IDX_W] = state_reg.first_index;
		info_word[vp_pkg::INFO_LAST_LSB +: IDX_W] = state_reg.last_index;
		info_word[vp_pkg::INFO_ANY_BIT] = state_reg.any_active;
	end

	assign wr_control = reg_write && (reg_addr == vp_pkg::FP_CONTROL_OFFSET);
	assign wr_status = reg_write && (reg_addr == vp_pkg::FP_STATUS_OFFSET);
	assign wr_command = reg_write && (reg_addr == vp_pkg::COMMAND_OFFSET);
	assign wr_irq_status = reg_write && (reg_addr == vp_pkg::IRQ_STATUS_OFFSET);
	assign wr_irq_mask = reg_write && (reg_addr == vp_pkg::IRQ_MASK_OFFSET);

	// Events feeding the sticky interrupt status
	always_comb begin
		irq_events = 4'h0;
		irq_events[vp_pkg::IRQ_FAULT_TAKEN] = take_now;
		irq_events[vp_pkg::IRQ_FAULT_SUPPRESS] = suppress_now;
		irq_events[vp_pkg::IRQ_FP_TRAP] = (trapped != 5'h00) || ide_trap_now;
		irq_events[vp_pkg::IRQ_INPUT_DENORMAL] = idc_now && !ide_trap_now;
	end

	// Register file, datapath results and interrupt
	always_comb begin
		state_next = state_reg;

		// Read data stand in the cycle after the strobe only
		state_next.rdata = 32'h0000_0000;
		if (reg_read) begin
			if (reg_addr == vp_pkg::FP_CONTROL_OFFSET) begin
				state_next.rdata = state_reg.fp_control;
			end else if (reg_addr == vp_pkg::FP_STATUS_OFFSET) begin
				state_next.rdata = state_reg.fp_status;
			end else if (reg_addr == vp_pkg::FAULT_MASK_OFFSET) begin
				state_next.rdata = 32'(state_reg.fault_mask);
			end else if (reg_addr == vp_pkg::ELEMENT_INFO_OFFSET) begin
				state_next.rdata = info_word;
			end else if (reg_addr == vp_pkg::IRQ_STATUS_OFFSET) begin
				state_next.rdata = 32'(state_reg.irq_status);
			end else if (reg_addr == vp_pkg::IRQ_MASK_OFFSET) begin
				state_next.rdata = 32'(state_reg.irq_mask);
			end else begin
				state_next.rdata = 32'h0000_0000;
			end
		end

		// Control and mask writes
		if (wr_control) begin
			state_next.fp_control = reg_wdata & vp_pkg::CONTROL_WRITE_MASK;
		end
		if (wr_irq_mask) begin
			state_next.irq_mask = reg_wdata[vp_pkg::IRQ_W-1:0];
		end

		// Status write first, hardware flags then set over it
		if (wr_status) begin
			state_next.fp_status = reg_wdata & vp_pkg::STATUS_WRITE_MASK;
		end
		state_next.fp_status[vp_pkg::EXC_FLAG_LSB +: vp_pkg::EXC_W] =
			state_next.fp_status[vp_pkg::EXC_FLAG_LSB +: vp_pkg::EXC_W] | untrapped;
		if (idc_now && !ide_trap_now) begin
			state_next.fp_status[vp_pkg::INPUT_DENORMAL_BIT] = 1'b1;
		end

		// Set-all first, a load recorded in the same cycle clears after it
		if (wr_command && reg_wdata[vp_pkg::CMD_SET_ALL_BIT]) begin
			state_next.fault_mask = '1;
		end
		if (suppress_now) begin
			// Only clears, never sets, from the failed element upward
			state_next.fault_mask = state_next.fault_mask & below_fault;
		end

		// Sticky interrupt status, write one to clear, set wins
		if (wr_irq_status) begin
			state_next.irq_status = state_reg.irq_status & ~reg_wdata[vp_pkg::IRQ_W-1:0];
		end
		state_next.irq_status = state_next.irq_status | irq_events;
		state_next.irq = (state_next.irq_status & state_next.irq_mask) != 4'h0;

		// Vector result, one cycle after the request
		state_next.result_valid = op_valid;
		state_next.fault_take = take_now;
		if (op_valid) begin
			state_next.result_data = merged_data;
			state_next.result_active = lane_active;
			state_next.first_index = IDX_W'(first_lane >> op_elem_size);
			state_next.last_index = IDX_W'(last_lane >> op_elem_size);
			state_next.any_active = found_active;
		end

		// Effective half-precision controls per operation
		state_next.fp_done = fp_valid;
		state_next.fp_trap = (trapped != 5'h00) || ide_trap_now;
		if (fp_valid) begin
			state_next.fp_flush = flush_now;
			state_next.fp_alt_half = fp_half ? 1'b0 : ctl_ahp;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.fp_control <= vp_pkg::CONTROL_RESET;
			state_reg.fp_status <= vp_pkg::STATUS_RESET;
			state_reg.fault_mask <= '1;
			state_reg.irq_status <= vp_pkg::IRQ_RESET;
			state_reg.irq_mask <= vp_pkg::IRQ_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign reg_rdata = state_reg.rdata;
	assign result_valid = state_reg.result_valid;
	assign result_data = state_reg.result_data;
	assign result_active = state_reg.result_active;
	assign fault_take = state_reg.fault_take;
	assign first_active_index = state_reg.first_index;
	assign last_active_index = state_reg.last_index;
	assign any_active = state_reg.any_active;
	assign fp_done = state_reg.fp_done;
	assign fp_flush = state_reg.fp_flush;
	assign fp_alt_half = state_reg.fp_alt_half;
	assign fp_trap = state_reg.fp_trap;
	assign irq = state_reg.irq;

endmodule : vector_predication_fp16_control

// ===== bench/vector_predication_fp16_control_chk.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker
// ****************************************************************
module vector_predication_fp16_control_chk #(
	parameter int BYTES = 16
) (
	input wire logic                     clock,
	input wire logic                     reset,
	input wire logic                     op_valid,
	input vp_pkg::op_kind_type           op_kind,
	input wire logic                     op_predicated,
	input wire logic                     op_zeroing,
	input wire logic [1:0]               op_elem_size,
	input wire logic [BYTES-1:0]         op_pred,
	input wire logic [BYTES-1:0]         op_fault,
	input wire logic [8*BYTES-1:0]       op_old_data,
	input wire logic [8*BYTES-1:0]       op_new_data,
	input wire logic                     result_valid,
	input wire logic [8*BYTES-1:0]       result_data,
	input wire logic [BYTES-1:0]         result_active,
	input wire logic                     fault_take,
	input wire logic [$clog2(BYTES)-1:0] first_active_index,
	input wire logic [$clog2(BYTES)-1:0] last_active_index,
	input wire logic                     any_active,
	input wire logic                     fp_valid,
	input wire logic                     fp_half,
	input wire logic                     fp_convert,
	input wire logic                     fp_done,
	input wire logic                     fp_flush,
	input wire logic                     fp_alt_half
);
	localparam int IW = $clog2(BYTES);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Expected byte-element result
	function automatic logic [8*BYTES-1:0] merge_bytes(input logic [BYTES-1:0] p, input logic z,
		input logic [8*BYTES-1:0] od, input logic [8*BYTES-1:0] nd);
		logic [8*BYTES-1:0] d;
		d = '0;
		for (int b = 0; b < BYTES; b++) d[8*b+:8] = p[b] ? nd[8*b+:8] : (z ? 8'h00 : od[8*b+:8]);
		return d;
	endfunction : merge_bytes
	// Request steps
	sequence s_op_taken; op_valid; endsequence
	sequence s_byte_pred_op; op_valid && op_predicated && op_elem_size == 2'h0; endsequence
	sequence s_half_op; fp_valid && fp_half; endsequence
	a_op_answer: assert property (s_op_taken |=> result_valid)
		else $error("no result");
	a_op_no_extra: assert property (!op_valid |=> !result_valid)
		else $error("extra result");
	a_pred_active: assert property (s_byte_pred_op |=> result_active == $past(op_pred))
		else $error("active lanes wrong");
	a_inactive_fill: assert property (s_byte_pred_op ##0 op_kind == vp_pkg::OP_PLAIN |=>
		result_data == merge_bytes($past(op_pred), $past(op_zeroing), $past(op_old_data),
		$past(op_new_data))) else $error("inactive lanes wrong");
	a_unpred_active: assert property (s_op_taken ##0 !op_predicated |=> &result_active)
		else $error("unpredicated lane inactive");
	a_first_last: assert property (op_valid && !op_predicated && op_elem_size == 2'h0 |=>
		first_active_index == '0 && last_active_index == IW'(BYTES - 1) && any_active)
		else $error("first or last wrong");
	a_first_fault: assert property (op_valid && op_kind == vp_pkg::OP_FIRST_FAULT &&
		!op_predicated && op_elem_size == 2'h0 |=> fault_take == $past(op_fault[0]))
		else $error("first-fault take wrong");
	a_non_fault: assert property (op_valid && op_kind == vp_pkg::OP_NON_FAULT |=> !fault_take)
		else $error("non-fault load faulted");
	a_half_format: assert property (s_half_op |=> fp_done && !fp_alt_half)
		else $error("half op alternate format");
	a_convert_flush: assert property (s_half_op ##0 fp_convert |=> !fp_flush)
		else $error("conversion flushed");
endmodule : vector_predication_fp16_control_chk

bind vector_predication_fp16_control vector_predication_fp16_control_chk #(.BYTES(BYTES)) u_chk (
	.clock(clock), .reset(reset), .op_valid(op_valid), .op_kind(op_kind),
	.op_predicated(op_predicated), .op_zeroing(op_zeroing), .op_elem_size(op_elem_size),
	.op_pred(op_pred), .op_fault(op_fault), .op_old_data(op_old_data), .op_new_data(op_new_data),
	.result_valid(result_valid), .result_data(result_data), .result_active(result_active),
	.fault_take(fault_take), .first_active_index(first_active_index),
	.last_active_index(last_active_index), .any_active(any_active), .fp_valid(fp_valid),
	.fp_half(fp_half), .fp_convert(fp_convert), .fp_done(fp_done), .fp_flush(fp_flush),
	.fp_alt_half(fp_alt_half));

// ===== bench/vector_predication_fp16_control_tb_top.sv
`timescale 1ns/100ps
module vector_predication_fp16_control_tb_top;
	localparam int                 BYTES = 16;
	localparam int                 IW    = $clog2(BYTES);
	localparam logic [8*BYTES-1:0] PAT   = {BYTES{8'hA5}};
	logic                clock, reset, reg_write, reg_read, op_valid, op_predicated, op_zeroing;
	logic                result_valid, fault_take, any_active, fp_valid, fp_half, fp_convert;
	logic                fp_input_denormal, fp_done, fp_flush, fp_alt_half, fp_trap, irq, p, z;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata, reg_rdata;
	vp_pkg::op_kind_type op_kind;
	logic [1:0]          op_elem_size, s;
	logic [BYTES-1:0]    op_pred, op_fault, result_active, pr;
	logic [8*BYTES-1:0]  op_old_data, op_new_data, result_data, od, nd;
	logic [IW-1:0]       first_active_index, last_active_index;
	logic [4:0]          fp_exceptions;
	logic [159:0]        ex, rq[$], oq[$], fq[$];
	logic                rd_seen = 1'b0;
	int                  errors = 0, checks = 0, cycles = 0, i;

	vector_predication_fp16_control #(.BYTES(BYTES)) u_dut (.*);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic cmp(input logic [159:0] g, input logic [159:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		rq.push_back(160'(e));
		@(posedge clock);
		reg_read <= 1'b0;
	endtask : rd
	// Expected outputs of one vector op
	function automatic logic [159:0] model(input logic [1:0] sz, input logic pd, zr,
		input logic [BYTES-1:0] pm, input logic [8*BYTES-1:0] o, n, input logic tk);
		logic [8*BYTES-1:0] d;
		logic [BYTES-1:0]   a;
		logic [IW-1:0]      f, l;
		logic               an, act;
		{d, a, f, l, an} = '0;
		for (int e = 0; e < (BYTES >> sz); e++) begin
			act = !pd || pm[e << sz];
			if (act && !an) f = IW'(e);
			if (act) l = IW'(e);
			an = an | act;
			for (int b = e << sz; b < ((e + 1) << sz); b++) begin
				a[b] = act;
				d[8*b+:8] = act ? n[8*b+:8] : (zr ? 8'h00 : o[8*b+:8]);
			end
		end
		return 160'({d, a, f, l, an, tk});
	endfunction : model
	task automatic op(input vp_pkg::op_kind_type k, input logic pd, zr, input logic [1:0] sz,
		input logic [BYTES-1:0] pm, ft, input logic [8*BYTES-1:0] o, n, input logic tk);
		@(posedge clock);
		op_valid      <= 1'b1;
		op_kind       <= k;
		op_predicated <= pd;
		op_zeroing    <= zr;
		op_elem_size  <= sz;
		op_pred       <= pm;
		op_fault      <= ft;
		op_old_data   <= o;
		op_new_data   <= n;
		oq.push_back(model(sz, pd, zr, pm, o, n, tk));
	endtask : op
	task automatic fp(input logic [31:0] c, input logic h, cv, dn, input logic [4:0] x,
		input logic fl, tr, input logic [31:0] st);
		wr(vp_pkg::FP_CONTROL_OFFSET, c);
		wr(vp_pkg::FP_STATUS_OFFSET, 32'h0);
		@(posedge clock);
		fp_valid          <= 1'b1;
		fp_half           <= h;
		fp_convert        <= cv;
		fp_input_denormal <= dn;
		fp_exceptions     <= x;
		fq.push_back(160'({fl, !h && c[vp_pkg::ALT_HALF_FORMAT_BIT], tr}));
		@(posedge clock);
		fp_valid <= 1'b0;
		rd(vp_pkg::FP_STATUS_OFFSET, st);
	endtask : fp

	// Clock source
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Result watcher
	always @(posedge clock) begin
		if (rd_seen) cmp(reg_rdata, rq.pop_front());
		rd_seen <= reg_read;
		if (result_valid) cmp({result_data, result_active, first_active_index,
			last_active_index, any_active, fault_take}, oq.pop_front());
		if (fp_done) cmp({fp_flush, fp_alt_half, fp_trap}, fq.pop_front());
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{reset, reg_write, reg_read, op_valid, op_predicated, op_zeroing} = 6'h20;
		{fp_valid, fp_half, fp_convert, fp_input_denormal, fp_exceptions} = 9'h000;
		{reg_addr, reg_wdata, op_elem_size, op_pred, op_fault, op_old_data, op_new_data} = '0;
		op_kind = vp_pkg::OP_PLAIN;
		void'($urandom(32'h33F55B0E));
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		rd(vp_pkg::FP_CONTROL_OFFSET, vp_pkg::CONTROL_RESET);
		rd(vp_pkg::FAULT_MASK_OFFSET, 32'h0000_FFFF);
		rd(vp_pkg::IRQ_STATUS_OFFSET, 32'h0);
		rd(8'h1C, 32'h0);
		wr(vp_pkg::FP_CONTROL_OFFSET, 32'hFFFF_FFFF);
		rd(vp_pkg::FP_CONTROL_OFFSET, vp_pkg::CONTROL_WRITE_MASK);
		wr(vp_pkg::FP_STATUS_OFFSET, 32'hFFFF_FFFF);
		rd(vp_pkg::FP_STATUS_OFFSET, vp_pkg::STATUS_WRITE_MASK);
		wr(vp_pkg::FAULT_MASK_OFFSET, 32'h0);
		rd(vp_pkg::FAULT_MASK_OFFSET, 32'h0000_FFFF);
		$display("test registers done");
		for (i = 0; i < 200; i++) begin
			s = 2'($urandom);
			{p, z} = 2'($urandom);
			pr = BYTES'($urandom);
			od = {$urandom, $urandom, $urandom, $urandom};
			nd = {$urandom, $urandom, $urandom, $urandom};
			ex = model(s, p, z, pr, od, nd, 1'b0);
			if (!ex[1]) pr[0] = 1'b1;
			op(vp_pkg::OP_PLAIN, p, z, s, pr, BYTES'($urandom), od, nd, 1'b0);
		end
		@(posedge clock);
		op_valid <= 1'b0;
		$display("test predication done");
		wr(vp_pkg::COMMAND_OFFSET, 32'h1);
		op(vp_pkg::OP_FIRST_FAULT, 1'b0, 1'b0, 2'h0, '1, 16'h0020, PAT, PAT, 1'b0);
		op(vp_pkg::OP_NON_FAULT, 1'b1, 1'b0, 2'h1, 16'h5555, 16'h0004, PAT, PAT, 1'b0);
		op(vp_pkg::OP_NON_FAULT, 1'b1, 1'b1, 2'h0, 16'h0001, 16'h0002, PAT, PAT, 1'b0);
		op(vp_pkg::OP_LOAD, 1'b0, 1'b0, 2'h0, '1, 16'h0100, PAT, PAT, 1'b1);
		op(vp_pkg::OP_FIRST_FAULT, 1'b0, 1'b0, 2'h0, '1, 16'h0001, PAT, PAT, 1'b1);
		@(posedge clock);
		op_valid <= 1'b0;
		rd(vp_pkg::FAULT_MASK_OFFSET, 32'h0000_0003);
		rd(vp_pkg::IRQ_STATUS_OFFSET, 32'h3);
		cmp(irq, 1'b0);
		wr(vp_pkg::IRQ_MASK_OFFSET, 32'h2);
		repeat (2) @(posedge clock);
		cmp(irq, 1'b1);
		wr(vp_pkg::IRQ_STATUS_OFFSET, 32'h2);
		repeat (2) @(posedge clock);
		cmp(irq, 1'b0);
		rd(vp_pkg::IRQ_STATUS_OFFSET, 32'h1);
		wr(vp_pkg::COMMAND_OFFSET, 32'h1);
		rd(vp_pkg::FAULT_MASK_OFFSET, 32'h0000_FFFF);
		$display("test fault mask done");
		fp(32'h0000_0006, 1'b1, 1'b0, 1'b1, 5'h00, 1'b1, 1'b0, 32'h0);
		fp(32'h0000_0001, 1'b1, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0, 32'h0);
		fp(32'h0000_0002, 1'b1, 1'b1, 1'b1, 5'h00, 1'b0, 1'b0, 32'h0);
		fp(32'h0000_0005, 1'b0, 1'b0, 1'b1, 5'h00, 1'b1, 1'b0, 32'h80);
		fp(32'h0000_8001, 1'b0, 1'b0, 1'b1, 5'h00, 1'b1, 1'b1, 32'h0);
		fp(32'h0000_0100, 1'b1, 1'b0, 1'b0, 5'h01, 1'b0, 1'b1, 32'h0);
		fp(32'h0000_0100, 1'b0, 1'b0, 1'b0, 5'h01, 1'b0, 1'b1, 32'h0);
		fp(32'h0000_0000, 1'b1, 1'b0, 1'b0, 5'h01, 1'b0, 1'b0, 32'h1);
		rd(vp_pkg::IRQ_STATUS_OFFSET, 32'hD);
		$display("test half precision done");
		repeat (4) @(posedge clock);
		cmp(rq.size() + oq.size() + fq.size(), 0);
		print_verdict();
	end
endmodule : vector_predication_fp16_control_tb_top
